// [logic/pio_pkg.sv]
// constants, field layouts and carriers shared by the dual parallel port block
// assumes a 32-bit classic wishbone bus and a single 40 MHz system clock
package pio_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PA_W = 16;
    localparam int PB_W = 12;
    localparam int PB_SEL_W = 8;
    localparam int EDGE_W = 4;
    localparam int EDGE_LSB = 8;

    // word-aligned register byte offsets
    localparam logic [7:0] PA_FSEL_OFS = 8'h00;
    localparam logic [7:0] PA_DIR_OFS = 8'h04;
    localparam logic [7:0] PA_DATA_OFS = 8'h08;
    localparam logic [7:0] PB_FSEL_OFS = 8'h0C;
    localparam logic [7:0] PB_DIR_OFS = 8'h10;
    localparam logic [7:0] PB_DATA_OFS = 8'h14;
    localparam logic [7:0] SYSCTL_OFS = 8'h18;
    localparam logic [7:0] GIMODE_OFS = 8'h1C;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h24;

    // reset values
    localparam logic [15:0] PA_FSEL_RST = 16'h0000;
    localparam logic [15:0] PA_DIR_RST = 16'h0000;
    localparam logic [15:0] PA_DATA_RST = 16'h0000;
    localparam logic [7:0] PB_FSEL_RST = 8'h80;
    localparam logic [11:0] PB_DIR_RST = 12'h000;
    localparam logic [11:0] PB_DATA_RST = 12'h000;
    localparam logic [0:0] SYSCTL_RST = 1'h0;
    localparam logic [0:0] GIMODE_RST = 1'h0;
    localparam logic [3:0] IRQ_STAT_RST = 4'h0;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // field positions
    localparam int WATCHDOG_OUT_PIN = 7;
    localparam int REFRESH_PIN = 8;
    localparam int CH2_RXCLK_PIN = 2;
    localparam int CH2_TXCLK_PIN = 3;
    localparam int CH3_RXCLK_PIN = 10;
    localparam int CH3_TXCLK_PIN = 11;

    // peripheral input ties while the pin is used as i/o
    localparam logic [15:0] PA_TIE_LOW = 16'h2555;
    localparam logic [15:0] PA_TIE_HIGH = 16'h8000;
    localparam logic [7:0] PB_TIE_LOW = 8'h28;

    typedef struct packed
    {
        logic cyc;
        logic stb;
        logic we;
        logic [ADDR_W-1:0] adr;
        logic [3:0] sel;
        logic [DATA_W-1:0] dat;
    } wb_req_t;

    typedef struct packed
    {
        logic [PA_W-1:0] out;
        logic [PA_W-1:0] oe;
    } pa_drive_t;

    typedef struct packed
    {
        logic [PB_W-1:0] out;
        logic [PB_W-1:0] oe;
    } pb_drive_t;
endpackage

// [logic/dual_parallel_io_ports.sv]
// two parallel ports (16 and 12 pins) with peripheral muxing and edge interrupts
// assumes pins and peripheral signals are synchronous to REF_CLK, wishbone classic slave
// Notes on behaviour
// RULE1 - port a: 16 pins, select 0 io, 1 peripheral
// RULE2 - io pin: direction 0 input, 1 output
// RULE3 - reset clears port a selects and directions
// RULE4 - data writes always update latch; outputs drive it
// RULE5 - output pin reads back its latch
// RULE6 - input pin latches writes, reads pin level
// RULE7 - peripheral mode: peripheral sets direction and data
// RULE8 - io-mode pins tie peripheral inputs to fixed levels
// RULE9 - io transmit clock pin: use receive clock pin
// RULE10 - io dma request pin holds request active
// RULE11 - port b: 12 pins, upper four always io
// RULE12 - port b low byte like port a; pin7 watchdog
// RULE13 - io timer input pins tie timer input low
// RULE14 - pin 8 optionally refresh request pin
// RULE15 - reset makes upper pins inputs, clears interrupt mode
// RULE16 - falling edge on upper input pin requests interrupt
// RULE17 - each edge request has its own mask bit
// RULE18 - pending bit sets even while masked
// RULE19 - two-flop sync, then falling edge one-cycle pulse
//
// The Wishbone register port and the placing of the registers were decided locally.
module dual_parallel_io_ports
(
    input wire logic REF_CLK, // system clock, 40 MHz
    input wire logic RST_N, // synchronous total system reset
    input wire logic WB_CYC_I, // bus cycle
    input wire logic WB_STB_I, // bus strobe
    input wire logic WB_WE_I, // write enable
    input wire logic [7:0] WB_ADR_I, // byte address
    input wire logic [3:0] WB_SEL_I, // byte lanes
    input wire logic [31:0] WB_DAT_I, // write data
    output logic [31:0] WB_DAT_O, // read data
    output logic WB_ACK_O, // acknowledge
    output logic IRQ, // level interrupt
    output logic [3:0] EDGE_REQ, // per-pin edge request pulses
    input wire logic [15:0] PA_IN, // port a pin levels
    output logic [15:0] PA_OUT, // port a pin drive value
    output logic [15:0] PA_OE, // port a pin drive enable
    input wire logic [11:0] PB_IN, // port b pin levels
    output logic [11:0] PB_OUT, // port b pin drive value
    output logic [11:0] PB_OE, // port b pin drive enable
    input wire logic [15:0] PA_PERIPH_OUT, // serial/dma output values
    input wire logic [15:0] PA_PERIPH_OE, // serial/dma output enables
    output logic [15:0] PA_PERIPH_IN, // inputs to serial/dma
    input wire logic [7:0] PB_PERIPH_OUT, // ack/timer/watchdog outputs
    input wire logic [7:0] PB_PERIPH_OE, // their output enables
    output logic [7:0] PB_PERIPH_IN, // inputs to ack logic and timers
    input wire logic REFRESH_REQ_IN // refresh controller request
);
    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
        input logic [3:0] sel);
        logic [15:0] m;
        m = old;
        if (sel[0])
        begin
            m[7:0] = wd[7:0];
        end
        if (sel[1])
        begin
            m[15:8] = wd[15:8];
        end
        return m;
    endfunction

    // data register read value per pin
    function automatic logic [15:0] pin_view(input logic [15:0] fsel, input logic [15:0] dir,
        input logic [15:0] latch, input logic [15:0] pin, input logic [15:0] per_oe,
        input logic [15:0] per_out);
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 0; i < 16; i++)
        begin
            if (fsel[i])
            begin
                v[i] = per_oe[i] ? per_out[i] : pin[i]; // [RULE7]
            end
            else
            begin
                v[i] = dir[i] ? latch[i] : pin[i]; // [RULE5] [RULE6]
            end
        end
        return v;
    endfunction

    pio_pkg::wb_req_t req;
    logic wr_en;
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic [15:0] pa_fsel_r, pa_fsel_nxt;
    logic [15:0] pa_dir_r, pa_dir_nxt;
    logic [15:0] pa_data_r, pa_data_nxt;
    logic [7:0] pb_fsel_r, pb_fsel_nxt;
    logic [11:0] pb_dir_r, pb_dir_nxt;
    logic [11:0] pb_data_r, pb_data_nxt;
    logic sysctl_r, sysctl_nxt;
    logic gimode_r, gimode_nxt;
    logic [3:0] stat_r, stat_nxt;
    logic [3:0] mask_r, mask_nxt;
    logic [3:0] sync1_r, sync2_r, sync3_r;
    logic [3:0] fall;
    logic [3:0] edge_r, edge_nxt;
    logic irq_r, irq_nxt;
    pio_pkg::pa_drive_t pa_drv_r, pa_drv_nxt;
    pio_pkg::pb_drive_t pb_drv_r, pb_drv_nxt;
    logic [15:0] pa_pin_in_r, pa_pin_in_nxt;
    logic [7:0] pb_pin_in_r, pb_pin_in_nxt;
    logic [15:0] pa_view, pb_view16;
    logic [11:0] pb_fsel_ext;

    assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I, sel: WB_SEL_I, dat: WB_DAT_I};
    // write lands on the edge where the master sees ack
    assign wr_en = req.cyc & req.stb & req.we & ack_r;

    // upper four pins have no select bit, so they read as io
    assign pb_fsel_ext = {4'h0, pb_fsel_r};
    assign pa_view = pin_view(pa_fsel_r, pa_dir_r, pa_data_r, PA_IN, PA_PERIPH_OE, PA_PERIPH_OUT);
    assign pb_view16 = pin_view({8'h00, pb_fsel_r}, {4'h0, pb_dir_r}, {4'h0, pb_data_r}, {4'h0, PB_IN},
        {8'h00, PB_PERIPH_OE}, {8'h00, PB_PERIPH_OUT}); // [RULE12]

    // bus answer: ack one cycle after request, dropped the cycle after
    always_comb
    begin
        ack_nxt = req.cyc & req.stb & ~ack_r;
        rdat_nxt = 32'h0000_0000;
        unique case (req.adr)
            pio_pkg::PA_FSEL_OFS: rdat_nxt[15:0] = pa_fsel_r;
            pio_pkg::PA_DIR_OFS: rdat_nxt[15:0] = pa_dir_r;
            pio_pkg::PA_DATA_OFS: rdat_nxt[15:0] = pa_view;
            pio_pkg::PB_FSEL_OFS: rdat_nxt[7:0] = pb_fsel_r;
            pio_pkg::PB_DIR_OFS: rdat_nxt[11:0] = pb_dir_r;
            pio_pkg::PB_DATA_OFS: rdat_nxt[11:0] = pb_view16[11:0];
            pio_pkg::SYSCTL_OFS: rdat_nxt[0] = sysctl_r;
            pio_pkg::GIMODE_OFS: rdat_nxt[0] = gimode_r;
            pio_pkg::IRQ_STAT_OFS: rdat_nxt[3:0] = stat_r;
            pio_pkg::IRQ_MASK_OFS: rdat_nxt[3:0] = mask_r;
            default: rdat_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // configuration and data registers
    always_comb
    begin
        pa_fsel_nxt = pa_fsel_r;
        pa_dir_nxt = pa_dir_r;
        pa_data_nxt = pa_data_r;
        pb_fsel_nxt = pb_fsel_r;
        pb_dir_nxt = pb_dir_r;
        pb_data_nxt = pb_data_r;
        sysctl_nxt = sysctl_r;
        gimode_nxt = gimode_r;
        mask_nxt = mask_r;
        if (wr_en)
        begin
            unique case (req.adr)
                pio_pkg::PA_FSEL_OFS: pa_fsel_nxt = merge16(pa_fsel_r, req.dat, req.sel); // [RULE1]
                pio_pkg::PA_DIR_OFS: pa_dir_nxt = merge16(pa_dir_r, req.dat, req.sel); // [RULE2]
                pio_pkg::PA_DATA_OFS: pa_data_nxt = merge16(pa_data_r, req.dat, req.sel); // [RULE4]
                pio_pkg::PB_FSEL_OFS: pb_fsel_nxt = req.sel[0] ? req.dat[7:0] : pb_fsel_r; // [RULE11]
                pio_pkg::PB_DIR_OFS: pb_dir_nxt = 12'(merge16({4'h0, pb_dir_r}, req.dat, req.sel));
                pio_pkg::PB_DATA_OFS: pb_data_nxt = 12'(merge16({4'h0, pb_data_r}, req.dat, req.sel)); // [RULE4]
                pio_pkg::SYSCTL_OFS: sysctl_nxt = req.sel[0] ? req.dat[0] : sysctl_r;
                pio_pkg::GIMODE_OFS: gimode_nxt = req.sel[0] ? req.dat[0] : gimode_r;
                pio_pkg::IRQ_MASK_OFS: mask_nxt = req.sel[0] ? req.dat[3:0] : mask_r; // [RULE17]
                default: mask_nxt = mask_r;
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            pa_fsel_r <= pio_pkg::PA_FSEL_RST; // [RULE3]
            pa_dir_r <= pio_pkg::PA_DIR_RST; // [RULE3]
            pa_data_r <= pio_pkg::PA_DATA_RST;
            pb_fsel_r <= pio_pkg::PB_FSEL_RST; // [RULE12]
            pb_dir_r <= pio_pkg::PB_DIR_RST; // [RULE15]
            pb_data_r <= pio_pkg::PB_DATA_RST;
            sysctl_r <= pio_pkg::SYSCTL_RST;
            gimode_r <= pio_pkg::GIMODE_RST; // [RULE15]
            mask_r <= pio_pkg::IRQ_MASK_RST;
        end
        else
        begin
            pa_fsel_r <= pa_fsel_nxt;
            pa_dir_r <= pa_dir_nxt;
            pa_data_r <= pa_data_nxt;
            pb_fsel_r <= pb_fsel_nxt;
            pb_dir_r <= pb_dir_nxt;
            pb_data_r <= pb_data_nxt;
            sysctl_r <= sysctl_nxt;
            gimode_r <= gimode_nxt;
            mask_r <= mask_nxt;
        end
    end

    // pin drive and peripheral inputs, all registered for clean outputs
    always_comb
    begin
        for (int i = 0; i < pio_pkg::PA_W; i++)
        begin
            pa_drv_nxt.out[i] = pa_fsel_r[i] ? PA_PERIPH_OUT[i] : pa_data_r[i]; // [RULE4] [RULE7]
            pa_drv_nxt.oe[i] = pa_fsel_r[i] ? PA_PERIPH_OE[i] : pa_dir_r[i]; // [RULE2] [RULE7]
        end
        for (int i = 0; i < pio_pkg::PB_W; i++)
        begin
            if (pb_fsel_ext[i])
            begin
                pb_drv_nxt.out[i] = PB_PERIPH_OUT[i];
                pb_drv_nxt.oe[i] = PB_PERIPH_OE[i];
            end
            else
            begin
                pb_drv_nxt.out[i] = pb_data_r[i];
                pb_drv_nxt.oe[i] = pb_dir_r[i]; // [RULE11]
            end
        end
        // watchdog pin only ever pulls low: open drain
        if (pb_fsel_r[pio_pkg::WATCHDOG_OUT_PIN])
        begin
            pb_drv_nxt.out[pio_pkg::WATCHDOG_OUT_PIN] = 1'b0;
            pb_drv_nxt.oe[pio_pkg::WATCHDOG_OUT_PIN] = ~PB_PERIPH_OUT[pio_pkg::WATCHDOG_OUT_PIN]; // [RULE12]
        end
        if (sysctl_r)
        begin
            pb_drv_nxt.out[pio_pkg::REFRESH_PIN] = REFRESH_REQ_IN; // [RULE14]
            pb_drv_nxt.oe[pio_pkg::REFRESH_PIN] = 1'b1;
        end
        // io-mode pins in the tie masks hand the peripheral a fixed level instead of the pin
        pa_pin_in_nxt = (PA_IN & pa_fsel_r) | (pio_pkg::PA_TIE_HIGH & ~pa_fsel_r); // [RULE8] [RULE10]
        if (!pa_fsel_r[pio_pkg::CH2_TXCLK_PIN])
        begin
            pa_pin_in_nxt[pio_pkg::CH2_TXCLK_PIN] = pa_pin_in_nxt[pio_pkg::CH2_RXCLK_PIN]; // [RULE9]
        end
        if (!pa_fsel_r[pio_pkg::CH3_TXCLK_PIN])
        begin
            pa_pin_in_nxt[pio_pkg::CH3_TXCLK_PIN] = pa_pin_in_nxt[pio_pkg::CH3_RXCLK_PIN]; // [RULE9]
        end
        // outputs-only functions see the pin; the low ties are covered by the and above
        pa_pin_in_nxt = pa_pin_in_nxt | (PA_IN & ~pa_fsel_r & ~pio_pkg::PA_TIE_LOW & ~pio_pkg::PA_TIE_HIGH
            & ~(16'h0001 << pio_pkg::CH2_TXCLK_PIN) & ~(16'h0001 << pio_pkg::CH3_TXCLK_PIN));
        pb_pin_in_nxt = (PB_IN[7:0] & pb_fsel_r) | (PB_IN[7:0] & ~pb_fsel_r & ~pio_pkg::PB_TIE_LOW); // [RULE13]
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            pa_drv_r <= '0;
            pb_drv_r <= '0;
            pa_pin_in_r <= 16'h0000;
            pb_pin_in_r <= 8'h00;
        end
        else
        begin
            pa_drv_r <= pa_drv_nxt;
            pb_drv_r <= pb_drv_nxt;
            pa_pin_in_r <= pa_pin_in_nxt;
            pb_pin_in_r <= pb_pin_in_nxt;
        end
    end

    // upper pins: sync, falling-edge detect, sticky status
    // sync1 is only read by sync2
    genvar g;
    generate
        for (g = 0; g < pio_pkg::EDGE_W; g++)
        begin : g_edge
            assign fall[g] = sync3_r[g] & ~sync2_r[g] & ~pb_dir_r[pio_pkg::EDGE_LSB + g] & gimode_r; // [RULE16]
        end
    endgenerate

    always_comb
    begin
        edge_nxt = fall; // [RULE19]
        stat_nxt = stat_r;
        if (wr_en && req.adr == pio_pkg::IRQ_STAT_OFS && req.sel[0])
        begin
            stat_nxt = stat_r & ~req.dat[3:0];
        end
        // a new edge wins over a same-cycle clear
        stat_nxt = stat_nxt | fall; // [RULE18]
        irq_nxt = |(stat_nxt & mask_r); // [RULE17]
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            sync3_r <= 4'h0;
            edge_r <= 4'h0;
            stat_r <= pio_pkg::IRQ_STAT_RST;
            irq_r <= 1'b0;
        end
        else
        begin
            sync1_r <= PB_IN[11:8]; // [RULE19]
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            edge_r <= edge_nxt;
            stat_r <= stat_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = rdat_r;
    assign IRQ = irq_r;
    assign EDGE_REQ = edge_r;
    assign PA_OUT = pa_drv_r.out;
    assign PA_OE = pa_drv_r.oe;
    assign PB_OUT = pb_drv_r.out;
    assign PB_OE = pb_drv_r.oe;
    assign PA_PERIPH_IN = pa_pin_in_r;
    assign PB_PERIPH_IN = pb_pin_in_r;
endmodule

// [verification/pio_chk.sv]
// pin and bus assertions for the dual parallel port block
// assumes it is bound to the block's top module, one clock domain
module pio_chk
(
    input wire logic REF_CLK, // system clock
    input wire logic RST_N, // sync reset
    input wire logic WB_CYC_I, // bus cycle
    input wire logic WB_STB_I, // bus strobe
    input wire logic WB_WE_I, // write enable
    input wire logic [7:0] WB_ADR_I, // byte address
    input wire logic [31:0] WB_DAT_O, // read data
    input wire logic WB_ACK_O, // acknowledge
    input wire logic IRQ, // level interrupt
    input wire logic [3:0] EDGE_REQ, // edge pulses
    input wire logic [15:0] PA_IN, // port a pins
    input wire logic [15:0] PA_OUT, // port a drive
    input wire logic [15:0] PA_OE, // port a enable
    input wire logic [11:0] PB_IN, // port b pins
    input wire logic [11:0] PB_OE, // port b enable
    input wire logic [15:0] PA_PERIPH_IN, // to serial/dma
    input wire logic [7:0] PB_PERIPH_IN // to timers
);
    default clocking @(posedge REF_CLK); endclocking

    ack_time_a: assert property (disable iff (!RST_N) $rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O)
        else $error("bus request not answered in one cycle");
    ack_pulse_a: assert property (disable iff (!RST_N) WB_ACK_O |=> !WB_ACK_O)
        else $error("acknowledge longer than one cycle");
    reset_out_a: assert property (!RST_N |=> PA_OE == 16'h0000 && PB_OE == 12'h000 && !IRQ)
        else $error("pins driven or interrupt raised in reset");
    data_read_a: assert property (disable iff (!RST_N) WB_ACK_O && !WB_WE_I
        && WB_ADR_I == pio_pkg::PA_DATA_OFS && $stable(PA_OE) && $stable(PA_OUT) && $stable(PA_IN)
        |-> ((WB_DAT_O[15:0] ^ PA_OUT) & PA_OE) == 16'h0000 && ((WB_DAT_O[15:0] ^ PA_IN) & ~PA_OE) == 16'h0000)
        else $error("port a data read disagrees with pins");
    ties_a: assert property (disable iff (!RST_N) $past(RST_N) |->
        (PA_PERIPH_IN & pio_pkg::PA_TIE_LOW & ~$past(PA_IN)) == 16'h0000 && (PA_PERIPH_IN[15] || !$past(PA_IN[15]))
        && (PB_PERIPH_IN & pio_pkg::PB_TIE_LOW & ~$past(PB_IN[7:0])) == 8'h00)
        else $error("peripheral input not tied or passed");
    unmapped_a: assert property (disable iff (!RST_N) WB_ACK_O && !WB_WE_I && WB_ADR_I > pio_pkg::IRQ_MASK_OFS
        |-> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    edge_src_a: assert property (disable iff (!RST_N) (EDGE_REQ & ~($past(PB_IN[11:8], 4) & ~$past(PB_IN[11:8], 3)
        | $past(PB_IN[11:8], 5) & ~$past(PB_IN[11:8], 4) | $past(PB_IN[11:8], 6) & ~$past(PB_IN[11:8], 5))) == 4'h0)
        else $error("edge request without a falling pin");
    edge_pulse_a: assert property (disable iff (!RST_N) (EDGE_REQ & $past(EDGE_REQ)) == 4'h0)
        else $error("edge request longer than one cycle");
    irq_cause_a: assert property (disable iff (!RST_N) $rose(IRQ)
        |-> EDGE_REQ != 4'h0 || $past(WB_ACK_O) || $past(WB_ACK_O, 2))
        else $error("interrupt rose without edge or write");
    irq_hold_a: assert property (disable iff (!RST_N) $fell(IRQ) |-> $past(WB_ACK_O) || $past(WB_ACK_O, 2))
        else $error("interrupt fell without a write");
endmodule

bind dual_parallel_io_ports pio_chk chk_u
(
    .REF_CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .IRQ, .EDGE_REQ,
    .PA_IN, .PA_OUT, .PA_OE, .PB_IN, .PB_OE, .PA_PERIPH_IN, .PB_PERIPH_IN
);

// [verification/pio_board.sv]
// board side of both ports: resolves each pin from block and outside drivers
// assumes an outside driver always holds pins the block leaves undriven
module pio_board
(
    input wire logic [15:0] pa_out, // block drive value
    input wire logic [15:0] pa_oe, // block drive enable
    input wire logic [11:0] pb_out, // block drive value
    input wire logic [11:0] pb_oe, // block drive enable
    input wire logic [15:0] pa_ext, // outside level
    input wire logic [11:0] pb_ext, // outside level
    output logic [15:0] pa_pin, // resolved level
    output logic [11:0] pb_pin // resolved level
);
    // no pullups, so an undriven pin would float: outside level stands in
    assign pa_pin = (pa_out & pa_oe) | (pa_ext & ~pa_oe);
    assign pb_pin = (pb_out & pb_oe) | (pb_ext & ~pb_oe);
endmodule

// [verification/tb_dual_parallel_io_ports.sv]
// self-checking bench for the dual parallel port block
// assumes the board model resolves pins and the bench is the only bus master
module tb_dual_parallel_io_ports;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, rfr = 1'b0;
    logic [7:0] adr = 8'h00, pb_pout = 8'h00, pb_poe = 8'h00, pb_pi;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, irq;
    logic [3:0] edge_req;
    logic [15:0] pa_in, pa_out, pa_oe, pa_pi, pa_pout = 16'h0000, pa_poe = 16'h0000, pa_ext = 16'hA5C7;
    logic [11:0] pb_in, pb_out, pb_oe, pb_ext = 12'h3C3;
    logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h24};
    int n_errors = 0, total_checks = 0, n_edges = 0;

    dual_parallel_io_ports dut_u
    (
        .REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ(irq), .EDGE_REQ(edge_req),
        .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe),
        .PA_PERIPH_OUT(pa_pout), .PA_PERIPH_OE(pa_poe), .PA_PERIPH_IN(pa_pi), .PB_PERIPH_OUT(pb_pout),
        .PB_PERIPH_OE(pb_poe), .PB_PERIPH_IN(pb_pi), .REFRESH_REQ_IN(rfr)
    );
    pio_board board_u
    (
        .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe), .pa_ext(pa_ext), .pb_ext(pb_ext),
        .pa_pin(pa_in), .pb_pin(pb_in)
    );

    always #12.5 clk = ~clk;

    // count edge request pulses away from the launching edge
    always @(negedge clk)
    begin
        n_edges += $countones(edge_req);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // called just after an edge; two idle edges let registered pins settle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
            @(posedge clk);
        while (ack !== 1'b1 && n++ < 50);
        chk(32'(ack), 32'h1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        results();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (ofs[i]) rd(ofs[i], ofs[i] == 8'h0C ? 32'h80 : 32'h0);
        chk(32'(pa_oe), 32'h0);
        chk(32'(pb_oe), 32'h080);
        $display("test reset done");
        wr(8'h08, 32'h1234);
        rd(8'h08, 32'hA5C7);
        chk(32'(pa_oe), 32'h0);
        wr(8'h04, 32'hFF00);
        chk(32'(pa_oe), 32'hFF00);
        chk(32'(pa_out & 16'hFF00), 32'h1200);
        rd(8'h08, 32'h12C7);
        $display("test port a io done");
        pa_pout <= 16'h00A0;
        pa_poe <= 16'h00F0;
        wr(8'h04, 32'h0F0F);
        wr(8'h00, 32'h00FF);
        chk(32'(pa_oe), 32'h0FF0);
        chk(32'(pa_out & 16'h0FF0), 32'h02A0);
        rd(8'h08, 32'hA2A7);
        chk(32'(pa_pi), 32'h82A7);
        wr(8'h00, 32'h0004);
        chk(32'(pa_pi[3:2]), 32'h3);
        $display("test port a peripheral done");
        wr(8'h0C, 32'h0);
        wr(8'h10, 32'h0F0);
        wr(8'h14, 32'h5A5);
        chk(32'(pb_oe), 32'h0F0);
        chk(32'(pb_out & 12'h0F0), 32'h0A0);
        rd(8'h14, 32'h3A3);
        chk(32'(pb_pi), 32'h83);
        rfr <= 1'b1;
        wr(8'h18, 32'h1);
        chk(32'(pb_oe & pb_out & 12'h100), 32'h100);
        wr(8'h18, 32'h0);
        chk(32'(pb_oe & 12'h100), 32'h0);
        $display("test port b done");
        wr(8'h24, 32'h5);
        wr(8'h1C, 32'h1);
        pb_ext <= 12'h0C3;
        repeat (10) @(posedge clk);
        rd(8'h20, 32'h3);
        chk(32'(n_edges), 32'h2);
        chk(32'(irq), 32'h1);
        wr(8'h24, 32'h4);
        chk(32'(irq), 32'h0);
        rd(8'h20, 32'h3);
        wr(8'h20, 32'h1);
        rd(8'h20, 32'h2);
        wr(8'h24, 32'h2);
        chk(32'(irq), 32'h1);
        wr(8'h20, 32'h2);
        chk(32'(irq), 32'h0);
        // pin 10 as output falling from its latch must not count as an edge
        wr(8'h10, 32'h4F0);
        wr(8'h14, 32'h1A5);
        repeat (10) @(posedge clk);
        rd(8'h20, 32'h0);
        wr(8'h1C, 32'h0);
        pb_ext <= 12'h8C3;
        repeat (10) @(posedge clk);
        pb_ext <= 12'h0C3;
        repeat (10) @(posedge clk);
        rd(8'h20, 32'h0);
        wr(8'h40, 32'hFFFF);
        rd(8'h40, 32'h0);
        chk(32'(n_edges), 32'h2);
        $display("test interrupts done");
        results();
    end
endmodule
